/* hdl/irq_bank_cfg.svh */
/*
 * Constants of the maskable interrupt control bank: register addresses,
 * field positions, reset values and the bit layout of the grouped mask words.
 * Assumes byte addressing on a 32-bit address and 8-bit register data.
 */
`ifndef IRQ_BANK_CFG_SVH
`define IRQ_BANK_CFG_SVH

// number of maskable sources held by this bank
`define NUM_SRC    26
`define SRC_W      5

// fields of a source control register
`define FLAG_BIT   7
`define MASK_BIT   6
`define PRIO_MSB   2
`define ICR_RESET  8'h47
`define RST_FLAG   1'h0
`define RST_MASK   1'h1
`define RST_PRIO   3'h7

// control register addresses, source 25 first, source 0 last
`define ICR_OFS_LIST { \
  32'hFFFFF14E, 32'hFFFFF14C, 32'hFFFFF14A, 32'hFFFFF148, 32'hFFFFF146, \
  32'hFFFFF144, 32'hFFFFF142, 32'hFFFFF140, 32'hFFFFF13E, 32'hFFFFF13C, \
  32'hFFFFF13A, 32'hFFFFF130, 32'hFFFFF12E, 32'hFFFFF12C, 32'hFFFFF12A, \
  32'hFFFFF128, 32'hFFFFF126, 32'hFFFFF124, 32'hFFFFF122, 32'hFFFFF120, \
  32'hFFFFF11E, 32'hFFFFF118, 32'hFFFFF116, 32'hFFFFF114, 32'hFFFFF112, \
  32'hFFFFF110 }

// control register window, bits 5:3 of every read in it are zero
`define ICR_LO     32'hFFFFF110
`define ICR_HI     32'hFFFFF14F

// grouped mask words, four byte lanes from this base
`define MW_BASE    32'hFFFFF100
`define MW_BYTES   4
`define MW_RESET   32'hFFFFFFFF

// bit of each source inside the 32-bit grouped mask view, source 25 first
`define MW_POS_LIST { \
  5'h1F, 5'h1E, 5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h19, 5'h18, 5'h17, \
  5'h16, 5'h15, 5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A, \
  5'h09, 5'h08, 5'h07, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00 }

`endif

/* hdl/irq_bank_pkg.sv */
/*
 * Types shared by the interrupt control bank modules.
 * Assumes irq_bank_cfg.svh is on the include path.
 */
`include "irq_bank_cfg.svh"

package irq_bank_pkg;

  typedef logic [`NUM_SRC-1:0]      src_vec_t;
  typedef logic [`SRC_W-1:0]        src_idx_t;
  typedef logic [`PRIO_MSB:0]       prio_t;
  typedef logic [`NUM_SRC-1:0][2:0] prio_arr_t;

  typedef struct packed {
    src_vec_t  flag;
    src_vec_t  mask;
    prio_arr_t prio;
    logic [7:0] rd_data;
    logic      irq_req;
    src_idx_t  irq_src;
    prio_t     irq_level;
  } bank_state_t;

endpackage : irq_bank_pkg

/* hdl/arb_if.sv */
/*
 * Carrier between the control bank and its priority selector.
 * Assumes both ends run on the same clock; the selector is combinational.
 */
`timescale 1ns/1ps
`default_nettype none

interface arb_if;
  import irq_bank_pkg::*;
  src_vec_t  req;
  prio_arr_t lvl;
  logic      hit;
  src_idx_t  idx;
  prio_t     win_lvl;
  modport ctrl (output req, output lvl, input hit, input idx, input win_lvl);
  modport sel  (input req, input lvl, output hit, output idx, output win_lvl);
endinterface : arb_if

`default_nettype wire

/* hdl/irq_prio_select.sv */
/*
 * Picks the winning request: lowest programmable level first, then the
 * lower source index as the fixed default order.
 * Assumes req already excludes masked and acknowledged sources.
 */
`timescale 1ns/1ps
`default_nettype none

module irq_prio_select
  import irq_bank_pkg::*;
(
  // selector side of the carrier
  arb_if.sel arb
);

  logic     hit;
  src_idx_t idx;
  prio_t    best;

  // walk from the highest index down so an equal level keeps the lower index
  always_comb begin
    hit  = 1'b0;
    idx  = '0;
    best = 3'h7;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (arb.req[i] && (!hit || arb.lvl[i] <= best)) begin
        hit  = 1'b1;
        idx  = src_idx_t'(i);
        best = arb.lvl[i];
      end
    end
  end

  assign arb.hit     = hit;
  assign arb.idx     = idx;
  assign arb.win_lvl = best;

endmodule : irq_prio_select

`default_nettype wire

/* hdl/irq_ctrl_bank.sv */
/*
 * Control bank for the maskable interrupts: one control register per source
 * holding request flag, mask flag and priority level, a grouped mask word view
 * of the same mask bits, and the request presented to the processor core.
 * Assumes request lines, acknowledge and core_busy are on sys_clk.
 */
// Added by the designer: the plain strobed port.
// What this block does
// - one control register owns each source
// - byte writes and single-bit writes both supported
// - bit 7 flag, set by request, cleared on acknowledge
// - bit 6 mask, one holds request pending
// - registers from FFFFF110 by halfword, bits 5:3 zero
// - pending while masked or core busy, then presented
// - equal levels resolved by fixed source order
// - one mask bit shared with grouped mask word
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl_bank
  import irq_bank_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // register port
  input  wire logic [31:0] bus_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_strobe,
  input  wire logic        wr_bit,
  input  wire logic [2:0]  wr_bit_sel,
  input  wire logic        rd_strobe,
  output logic      [7:0]  rd_data,
  // peripheral request pulses, one per source
  input  wire logic [`NUM_SRC-1:0] src_req,
  // processor core side
  input  wire logic              core_busy,
  input  wire logic              ack_valid,
  input  wire logic [`SRC_W-1:0] ack_src,
  output logic                   irq_req,
  output logic      [`SRC_W-1:0] irq_src,
  output logic      [2:0]        irq_level
);

  localparam logic [`NUM_SRC*32-1:0] ICR_OFS = `ICR_OFS_LIST;
  localparam logic [`NUM_SRC*5-1:0]  MW_POS  = `MW_POS_LIST;

  localparam bank_state_t RST_STATE = '{
    flag:      {`NUM_SRC{`RST_FLAG}},
    mask:      {`NUM_SRC{`RST_MASK}},
    prio:      {`NUM_SRC{`RST_PRIO}},
    rd_data:   8'h00,
    irq_req:   1'b0,
    irq_src:   '0,
    irq_level: 3'h0
  };

  bank_state_t s_q;
  bank_state_t s_d;
  src_vec_t    ack_hot;
  logic [7:0]  nv;
  logic [31:0] mw;
  logic [4:0]  pos;

  arb_if arb ();

  irq_prio_select u_sel (
    .arb (arb.sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // mask of the bits a write may touch; a bit op leaves the rest alone
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [7:0] wd,
                                        input logic       bit_op,
                                        input logic [2:0] sel);
    logic [7:0] m;
    m = bit_op ? (8'h01 << sel) : 8'hFF;
    return (old & ~m) | (wd & m);
  endfunction : merge8

  // grouped mask view; bits owned by no source read as one
  function automatic logic [31:0] mw_view(input src_vec_t mask);
    logic [31:0] v;
    v = `MW_RESET;
    for (int i = 0; i < `NUM_SRC; i++) begin
      v[MW_POS[i*5 +: 5]] = mask[i];
    end
    return v;
  endfunction : mw_view

  function automatic logic [7:0] icr_view(input bank_state_t s, input int i);
    return {s.flag[i], s.mask[i], 3'b000, s.prio[i]};
  endfunction : icr_view

  ////////////////////////////////////////////////////////////////////////////
  // selector feed

  // a source being acknowledged is kept out so it cannot be offered twice
  assign ack_hot  = ack_valid ? (src_vec_t'(1) << ack_src) : '0;
  assign arb.req  = s_q.flag & ~s_q.mask & ~ack_hot;
  assign arb.lvl  = s_q.prio;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nv        = 8'h00;
    pos       = 5'h00;
    mw        = mw_view(s_q.mask);
    s_d       = s_q;
    s_d.rd_data = 8'h00;

    // acknowledge clears the flag of the source taken by the core
    if (ack_valid && ack_src < `SRC_W'(`NUM_SRC)) begin
      s_d.flag[ack_src] = 1'b0;
    end

    if (wr_strobe) begin
      for (int i = 0; i < `NUM_SRC; i++) begin
        if (bus_addr == ICR_OFS[i*32 +: 32]) begin
          nv = merge8(icr_view(s_q, i), wr_data, wr_bit, wr_bit_sel);
          s_d.flag[i] = nv[`FLAG_BIT];
          s_d.mask[i] = nv[`MASK_BIT];
          s_d.prio[i] = nv[`PRIO_MSB:0];
        end
      end
      for (int k = 0; k < `MW_BYTES; k++) begin
        if (bus_addr == `MW_BASE + 32'(k)) begin
          nv = merge8(mw[k*8 +: 8], wr_data, wr_bit, wr_bit_sel);
          for (int i = 0; i < `NUM_SRC; i++) begin
            pos = MW_POS[i*5 +: 5];
            if (pos[4:3] == 2'(k)) begin
              s_d.mask[i] = nv[pos[2:0]];
            end
          end
        end
      end
    end

    // a request in the same cycle as a clear or write still lands
    s_d.flag = s_d.flag | src_req;

    if (rd_strobe) begin
      for (int i = 0; i < `NUM_SRC; i++) begin
        if (bus_addr == ICR_OFS[i*32 +: 32]) begin
          s_d.rd_data = icr_view(s_q, i);
        end
      end
      for (int k = 0; k < `MW_BYTES; k++) begin
        if (bus_addr == `MW_BASE + 32'(k)) begin
          s_d.rd_data = mw[k*8 +: 8];
        end
      end
    end

    // held back while the core services another interrupt
    s_d.irq_req   = arb.hit && !core_busy;
    s_d.irq_src   = arb.idx;
    s_d.irq_level = arb.win_lvl;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data   = s_q.rd_data;
  assign irq_req   = s_q.irq_req;
  assign irq_src   = s_q.irq_src;
  assign irq_level = s_q.irq_level;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_req_sets;
    src_req[0] |=> s_q.flag[0] ##1 (s_q.flag[0] || $past(ack_valid) || $past(wr_strobe));
  endproperty
  a_req_sets: assert property (p_req_sets) else $error("request did not set flag");

  property p_ack_clears;
    ack_valid && ack_src == 5'h00 && !src_req[0] |=> !s_q.flag[0];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("acknowledge left flag set");

  property p_mask_blocks;
    s_q.mask[0] && arb.req == src_vec_t'(0) |=> !(irq_req && irq_src == 5'h00);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked source presented");

  property p_busy_holds;
    core_busy |=> !irq_req;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("request offered while busy");

  property p_pending_shown;
    s_q.flag[0] && !s_q.mask[0] && s_q.prio[0] == 3'h0 && !core_busy && !ack_valid
      |=> irq_req && irq_src == 5'h00 && irq_level == 3'h0;
  endproperty
  a_pending_shown: assert property (p_pending_shown) else $error("pending source not shown");

  property p_tie_order;
    arb.req[0] && arb.req[1] && s_q.prio[0] == s_q.prio[1]
      |-> arb.idx == 5'h00 || arb.win_lvl < s_q.prio[0];
  endproperty
  a_tie_order: assert property (p_tie_order) else $error("tie not won by lower index");

  property p_level_wins;
    arb.hit |-> arb.win_lvl == s_q.prio[arb.idx] && arb.req[arb.idx];
  endproperty
  a_level_wins: assert property (p_level_wins) else $error("winner level mismatch");

  property p_icr_read;
    rd_strobe && bus_addr == 32'hFFFFF110
      |=> rd_data == {$past(s_q.flag[0]), $past(s_q.mask[0]), 3'b000, $past(s_q.prio[0])};
  endproperty
  a_icr_read: assert property (p_icr_read) else $error("control register read wrong");

  property p_zero_bits;
    rd_strobe && bus_addr >= `ICR_LO && bus_addr <= `ICR_HI |=> rd_data[5:3] == 3'b000;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved bits not zero");

  property p_bit_op;
    wr_strobe && wr_bit && wr_bit_sel == 3'h6 && bus_addr == 32'hFFFFF110
      |=> s_q.mask[0] == $past(wr_data[6]) && s_q.prio[0] == $past(s_q.prio[0]);
  endproperty
  a_bit_op: assert property (p_bit_op) else $error("bit write disturbed other fields");

  property p_byte_write;
    wr_strobe && !wr_bit && bus_addr == 32'hFFFFF112
      |=> s_q.prio[1] == $past(wr_data[2:0]) && s_q.prio[0] == $past(s_q.prio[0]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write hit wrong source");

  property p_word_mask;
    wr_strobe && !wr_bit && bus_addr == `MW_BASE
      |=> s_q.mask[0] == $past(wr_data[0]) && s_q.mask[5] == $past(wr_data[7]);
  endproperty
  a_word_mask: assert property (p_word_mask) else $error("grouped mask write not shared");

endmodule : irq_ctrl_bank

`default_nettype wire

/* bench/core_model.sv */
/*
 * Processor core stand-in: takes the presented request, acknowledges it
 * with a one-cycle pulse and stays busy for a service time.
 * Assumes the bank on the same sys_clk and reset.
 */
`include "irq_bank_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module core_model (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // bench control
  input  wire logic              accept,
  input  wire logic [3:0]        hold_cycles,
  // bank side
  input  wire logic              irq_req,
  input  wire logic [`SRC_W-1:0] irq_src,
  output logic                   core_busy,
  output logic                   ack_valid,
  output logic      [`SRC_W-1:0] ack_src,
  // observation
  output logic      [`SRC_W-1:0] last_src,
  output logic      [7:0]        n_ack
);
  logic [3:0] busy_cnt;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_busy <= 1'h0;
      ack_valid <= 1'h0;
      ack_src   <= '0;
      last_src  <= '0;
      n_ack     <= 8'h00;
      busy_cnt  <= 4'h0;
    end else begin
      ack_valid <= 1'h0;
      // idle index shows garbage, never a stale valid value
      ack_src   <= ~last_src;
      if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
        if (busy_cnt == 4'h1) core_busy <= 1'h0;
      end else if (accept && irq_req && !core_busy) begin
        ack_valid <= 1'h1;
        ack_src   <= irq_src;
        last_src  <= irq_src;
        core_busy <= 1'h1;
        busy_cnt  <= hold_cycles;
        n_ack     <= n_ack + 8'h01;
      end
    end
  end
endmodule : core_model

`default_nettype wire

/* bench/tb.sv */
/*
 * Testbench of the interrupt control bank: register port tasks, request
 * pulses, and the core model acknowledging.
 * Assumes irq_ctrl_bank and core_model compiled before it.
 */
`include "irq_bank_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  import irq_bank_pkg::*;
  logic                   sys_clk, arst_n;
  logic [31:0]            bus_addr;
  logic [7:0]             wr_data, rd_data, n_ack;
  logic                   wr_strobe, wr_bit, rd_strobe, accept;
  logic                   core_busy, ack_valid, irq_req;
  logic [2:0]             wr_bit_sel, irq_level;
  src_vec_t               src_req;
  src_idx_t               ack_src, irq_src, last_src;
  logic [`NUM_SRC*32-1:0] ofs = `ICR_OFS_LIST;
  int                     n_errors, n_checks;

  irq_ctrl_bank u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_addr(bus_addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .wr_bit(wr_bit), .wr_bit_sel(wr_bit_sel),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .src_req(src_req), .core_busy(core_busy),
    .ack_valid(ack_valid), .ack_src(ack_src), .irq_req(irq_req), .irq_src(irq_src),
    .irq_level(irq_level));

  core_model u_core (.sys_clk(sys_clk), .arst_n(arst_n), .accept(accept),
    .hold_cycles(4'h5), .irq_req(irq_req), .irq_src(irq_src), .core_busy(core_busy),
    .ack_valid(ack_valid), .ack_src(ack_src), .last_src(last_src), .n_ack(n_ack));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task conclude;
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // strobe dropped and one edge let pass, so calls never collide
  task wr(input logic [31:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
    bus_addr   <= a;
    wr_data    <= d;
    wr_bit     <= b;
    wr_bit_sel <= s;
    wr_strobe  <= 1'h1;
    @(posedge sys_clk);
    wr_strobe  <= 1'h0;
    cyc(1);
  endtask : wr

  task rd(input logic [31:0] a, input logic [7:0] e);
    bus_addr  <= a;
    rd_strobe <= 1'h1;
    @(posedge sys_clk);
    rd_strobe <= 1'h0;
    #1;
    chk("rd_data", rd_data, e);
    cyc(1);
  endtask : rd

  task wait_ack(input logic [7:0] n);
    for (int k = 0; k < 60 && n_ack !== n; k++) @(posedge sys_clk);
    if (n_ack !== n) begin
      n_errors++;
      conclude();
    end
  endtask : wait_ack

  initial begin
    {bus_addr, wr_data, wr_strobe, wr_bit, wr_bit_sel, rd_strobe, src_req, accept} = '0;
    arst_n   = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    cyc(1);
    for (int i = 0; i < `NUM_SRC; i++) rd(ofs[i*32+:32], `ICR_RESET);
    rd(32'hFFFFF100, 8'hFF);
    wr(32'hFFFFF11A, 8'hFF, 1'h0, 3'h0);
    rd(32'hFFFFF11A, 8'h00);
    rd(32'hFFFFF111, 8'h00);
    wr(ofs[31:0], 8'h3D, 1'h0, 3'h0);
    rd(ofs[31:0], 8'h05);
    wr(ofs[31:0], 8'h40, 1'h1, 3'h6);
    rd(ofs[31:0], 8'h45);
    wr(ofs[31:0], 8'h00, 1'h1, 3'h0);
    rd(ofs[31:0], 8'h44);
    // masked request must stay pending
    src_req <= 26'h0000008;
    @(posedge sys_clk);
    src_req <= '0;
    cyc(4);
    rd(ofs[3*32+:32], 8'hC7);
    chk("irq_req", irq_req, 1'h0);
    wr(32'hFFFFF100, 8'h00, 1'h1, 3'h3);
    cyc(2);
    chk("irq_req", irq_req, 1'h1);
    chk("irq_src", irq_src, 5'h03);
    rd(32'hFFFFF100, 8'hF7);
    wr(ofs[1*32+:32], 8'h05, 1'h0, 3'h0);
    wr(ofs[2*32+:32], 8'h02, 1'h0, 3'h0);
    wr(ofs[4*32+:32], 8'h02, 1'h0, 3'h0);
    src_req <= 26'h0000016;
    @(posedge sys_clk);
    src_req <= '0;
    cyc(3);
    chk("irq_src", irq_src, 5'h02);
    chk("irq_level", irq_level, 3'h2);
    accept <= 1'h1;
    wait_ack(8'h04);
    chk("last_src", last_src, 5'h03);
    cyc(8);
    chk("irq_req", irq_req, 1'h0);
    rd(ofs[2*32+:32], 8'h02);
    rd(ofs[3*32+:32], 8'h07);
    // masked source 0 raises a request that must stay pending
    src_req <= 26'h0000001;
    @(posedge sys_clk);
    src_req <= '0;
    cyc(3);
    chk("irq_req", irq_req, 1'h0);
    rd(ofs[31:0], 8'hC4);
    conclude();
  end
endmodule : tb

`default_nettype wire
